// ==== common/icpbw_defs.svh ====
// Purpose: Offsets, field positions and limits of the input context decoder.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus, one aligned word per register.
// Notes: Definitions only.
`ifndef ICPBW_DEFS_SVH
`define ICPBW_DEFS_SVH
`define ICPBW_ADR_CMD       6'h00
`define ICPBW_ADR_CAPS      6'h01
`define ICPBW_ADR_DROP      6'h02
`define ICPBW_ADR_ADD       6'h03
`define ICPBW_ADR_CFGW      6'h04
`define ICPBW_ADR_EPMAP     6'h05
`define ICPBW_ADR_CTXEN     6'h06
`define ICPBW_ADR_CFGOUT    6'h07
`define ICPBW_ADR_STATUS    6'h08
`define ICPBW_ADR_GEOM      6'h09
`define ICPBW_TBL_BASE      3'h2
`define ICPBW_RPT_BASE      4'h6
`define ICPBW_OP_CTX        2'h1
`define ICPBW_OP_BW         2'h2
`define ICPBW_CMD_CFGEP     2
`define ICPBW_CMD_SETIF     3
`define ICPBW_CAP_CIC       0
`define ICPBW_CAP_CIE       1
`define ICPBW_CAP_CSZ       2
`define ICPBW_ST_DONE       1
`define ICPBW_PORTS         8
`define ICPBW_RPT_BYTES     16
`define ICPBW_LIM_HS        8'h50
`define ICPBW_LIM_FSSS      8'h5A
`define ICPBW_CTL_SZ_SMALL  7'h20
`define ICPBW_CTL_SZ_LARGE  7'h40
`endif

// ==== common/icpbw_pkg.sv ====
// Purpose: Types shared by the input context decoder modules.
// Assumes: Nothing beyond the defines header.
// Notes: Encodings are fixed binary codes.
package icpbw_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CTX = 2'b01, ST_BW = 2'b10} icpbw_state_e;
  typedef enum logic [1:0] {SPD_FS = 2'b00, SPD_HS = 2'b01, SPD_SS = 2'b10, SPD_RSV = 2'b11} icpbw_speed_e;
  typedef enum logic [1:0] {EP_CTRL = 2'b00, EP_ISO = 2'b01, EP_BULK = 2'b10, EP_INTR = 2'b11} icpbw_ep_e;
endpackage

// ==== common/icpbw_dec_if.sv ====
// Purpose: Carries decode and bandwidth signals between the top and its helpers.
// Assumes: Purely combinational helpers.
// Notes: One modport per party.
`timescale 1ns/10ps
interface icpbw_dec_if;
  import icpbw_pkg::*;
  logic [31:0]  drop_word;
  logic [31:0]  add_word;
  logic [31:0]  cfg_word;
  logic         config_info_capable;
  logic         config_info_enable;
  logic         context_size_select;
  logic         cfg_ep_cmd;
  logic         set_intf;
  logic [31:0]  drop_mask;
  logic [31:0]  add_mask;
  logic [23:0]  cfg_info;
  logic [6:0]   ctl_bytes;
  logic [3:0]   ep_num;
  logic         ep_dir;
  icpbw_ep_e    ep_type;
  logic [5:0]   ctx_index;
  logic [7:0]   bw_raw;
  icpbw_speed_e speed;
  logic [7:0]   bw_pct;
  modport top (output drop_word, add_word, cfg_word, config_info_capable, config_info_enable, context_size_select, cfg_ep_cmd, set_intf,
               ep_num, ep_dir, ep_type, bw_raw, speed,
               input drop_mask, add_mask, cfg_info, ctl_bytes, ctx_index, bw_pct);
  modport dec (input drop_word, add_word, cfg_word, config_info_capable, config_info_enable, context_size_select, cfg_ep_cmd, set_intf,
               ep_num, ep_dir, ep_type,
               output drop_mask, add_mask, cfg_info, ctl_bytes, ctx_index);
  modport bw  (input bw_raw, speed, output bw_pct);
endinterface

// ==== verilog/icpbw_ctx_decode.sv ====
// Purpose: Decodes the control words of an input control structure and maps endpoints to indices.
// Assumes: Words are stable while a command runs.
// Notes: Combinational only.
`timescale 1ns/10ps
`include "icpbw_defs.svh"
module icpbw_ctx_decode (
  icpbw_dec_if.dec d
);
  import icpbw_pkg::*;
  logic cfg_gate;

  // The two low drop bits are reserved; bit 0 of the add word names the control structure itself.
  assign d.drop_mask = {d.drop_word[31:2], 2'b00};
  assign d.add_mask  = {d.add_word[31:1], 1'b0};
  assign cfg_gate    = d.config_info_capable & d.config_info_enable & d.cfg_ep_cmd;
  // Reserved top byte is never passed on.
  assign d.cfg_info[7:0]   = cfg_gate ? d.cfg_word[7:0] : 8'h00;
  assign d.cfg_info[15:8]  = (cfg_gate & d.set_intf) ? d.cfg_word[15:8] : 8'h00;
  assign d.cfg_info[23:16] = (cfg_gate & d.set_intf) ? d.cfg_word[23:16] : 8'h00;
  assign d.ctl_bytes = d.context_size_select ? `ICPBW_CTL_SZ_LARGE : `ICPBW_CTL_SZ_SMALL;

  always_comb
  begin
    unique case (d.ep_type)
      EP_CTRL: d.ctx_index = {1'b0, d.ep_num, 1'b0} + 6'h02;
      EP_ISO, EP_BULK, EP_INTR: d.ctx_index = {1'b0, d.ep_num, 1'b1} + {5'h00, d.ep_dir};
    endcase
  end
endmodule

// ==== verilog/icpbw_bw_limit.sv ====
// Purpose: Limits a port's available periodic bandwidth to the range allowed at a speed.
// Assumes: Raw figure is a binary percentage.
// Notes: Combinational only.
`timescale 1ns/10ps
`include "icpbw_defs.svh"
module icpbw_bw_limit (
  icpbw_dec_if.bw b
);
  import icpbw_pkg::*;
  logic [7:0] lim;

  assign lim      = (b.speed == SPD_HS) ? `ICPBW_LIM_HS : `ICPBW_LIM_FSSS;
  // The byte stays a plain binary percentage, no decimal digit coding.
  assign b.bw_pct = (b.bw_raw > lim) ? lim : b.bw_raw;
endmodule

// ==== verilog/icpbw_top.sv ====
// Purpose: Input control structure decoder and root port bandwidth report, behind a Wishbone slave.
// Assumes: Software places the fetched control words in the word registers before a command.
// Notes: Writes take effect at the edge where ack is high; ack comes one cycle after the request.
`timescale 1ns/10ps
`include "icpbw_defs.svh"
module icpbw_top (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             busy_o,
  output logic      [31:0] ctx_enable_o
);
  import icpbw_pkg::*;

  icpbw_dec_if  dif ();
  icpbw_state_e state_ff;
  logic [31:0]  drop_ff;
  logic [31:0]  add_ff;
  logic [31:0]  cfgw_ff;
  logic [2:0]   caps_ff;
  logic [5:0]   cmd_ff;
  logic [6:0]   epmap_ff;
  logic [31:0]  fetch_ff;
  logic [23:0]  cfgout_ff;
  logic         done_ff;
  logic [3:0]   port_ff;
  logic [7:0]   tbl_ff [1:`ICPBW_PORTS];
  logic [7:0]   rpt_ff [0:`ICPBW_RPT_BYTES-1];
  logic         acc;
  logic         wr;
  logic         start;
  logic [5:0]   widx;

  assign acc   = wb_cyc_i & wb_stb_i;
  assign wr    = acc & wb_we_i & wb_ack_o;
  assign widx  = wb_adr_i[7:2];
  assign start = wr & (widx == `ICPBW_ADR_CMD) & (state_ff == ST_IDLE) & wb_sel_i[0];

  function automatic logic [31:0] f_merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    f_merge = o;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
        f_merge[8*i +: 8] = n[8*i +: 8];
    end
  endfunction

  assign dif.drop_word  = drop_ff;
  assign dif.add_word   = add_ff;
  assign dif.cfg_word   = cfgw_ff;
  assign dif.config_info_capable        = caps_ff[`ICPBW_CAP_CIC];
  assign dif.config_info_enable        = caps_ff[`ICPBW_CAP_CIE];
  assign dif.context_size_select        = caps_ff[`ICPBW_CAP_CSZ];
  assign dif.cfg_ep_cmd = cmd_ff[`ICPBW_CMD_CFGEP];
  assign dif.set_intf   = cmd_ff[`ICPBW_CMD_SETIF];
  assign dif.ep_num     = epmap_ff[3:0];
  assign dif.ep_dir     = epmap_ff[4];
  assign dif.ep_type    = icpbw_ep_e'(epmap_ff[6:5]);
  assign dif.speed      = icpbw_speed_e'(cmd_ff[5:4]);
  assign dif.bw_raw     = tbl_ff[port_ff + 4'h1];

  icpbw_ctx_decode u_dec (
    .d (dif.dec)
  );

  icpbw_bw_limit u_lim (
    .b (dif.bw)
  );

  // Command sequencer; commands written while busy are dropped.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_ff <= ST_IDLE;
      port_ff  <= 4'h0;
    end
    else
    begin
      unique case (state_ff)
        ST_IDLE:
        begin
          port_ff <= 4'h0;
          if (start && wb_dat_i[1:0] == `ICPBW_OP_CTX)
            state_ff <= ST_CTX;
          else if (start && wb_dat_i[1:0] == `ICPBW_OP_BW)
            state_ff <= ST_BW;
        end
        ST_CTX: state_ff <= ST_IDLE;
        ST_BW:
        begin
          port_ff <= port_ff + 4'h1;
          if (port_ff == 4'(`ICPBW_PORTS - 1))
            state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // Control words are frozen while a command runs, so a late write cannot tear the decode.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      drop_ff  <= 32'h0000_0000;
      add_ff   <= 32'h0000_0000;
      cfgw_ff  <= 32'h0000_0000;
      caps_ff  <= 3'h0;
      cmd_ff   <= 6'h00;
      epmap_ff <= 7'h00;
    end
    else if (wr && state_ff == ST_IDLE)
    begin
      unique case (widx)
        `ICPBW_ADR_DROP:  drop_ff  <= f_merge(drop_ff, wb_dat_i, wb_sel_i);
        `ICPBW_ADR_ADD:   add_ff   <= f_merge(add_ff, wb_dat_i, wb_sel_i);
        `ICPBW_ADR_CFGW:  cfgw_ff  <= f_merge(cfgw_ff, wb_dat_i, wb_sel_i);
        `ICPBW_ADR_CAPS:  caps_ff  <= wb_sel_i[0] ? wb_dat_i[2:0] : caps_ff;
        `ICPBW_ADR_CMD:   cmd_ff   <= wb_sel_i[0] ? wb_dat_i[5:0] : cmd_ff;
        `ICPBW_ADR_EPMAP: epmap_ff <= wb_sel_i[0] ? wb_dat_i[6:0] : epmap_ff;
        default:          epmap_ff <= epmap_ff;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 1; i <= `ICPBW_PORTS; i++)
        tbl_ff[i] <= 8'h00;
    end
    else if (wr && widx[5:3] == `ICPBW_TBL_BASE && wb_sel_i[0])
      tbl_ff[{1'b0, widx[2:0]} + 4'h1] <= wb_dat_i[7:0];
  end

  // Context state: drops first, then adds, so a context both dropped and added ends enabled.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      ctx_enable_o <= 32'h0000_0000;
      fetch_ff     <= 32'h0000_0000;
      cfgout_ff    <= 24'h00_0000;
    end
    else if (state_ff == ST_CTX)
    begin
      ctx_enable_o <= (ctx_enable_o & ~dif.drop_mask) | dif.add_mask;
      fetch_ff     <= dif.add_mask;
      cfgout_ff    <= dif.cfg_info;
    end
  end

  // Report bytes: byte 0 stays zero, byte k takes port k, bytes past the last port stay zero.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int i = 0; i < `ICPBW_RPT_BYTES; i++)
        rpt_ff[i] <= 8'h00;
    end
    else if (state_ff == ST_BW)
      rpt_ff[port_ff + 4'h1] <= dif.bw_pct;
  end

  // Done is sticky; a completion in the same cycle as a clear wins.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      done_ff <= 1'b0;
    else if (state_ff != ST_IDLE && !(state_ff == ST_BW && port_ff != 4'(`ICPBW_PORTS - 1)))
      done_ff <= 1'b1;
    else if (wr && widx == `ICPBW_ADR_STATUS && wb_sel_i[0] && wb_dat_i[`ICPBW_ST_DONE])
      done_ff <= 1'b0;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      busy_o <= 1'b0;
    else
      busy_o <= (state_ff == ST_BW && port_ff != 4'(`ICPBW_PORTS - 1)) || (state_ff == ST_IDLE && start);
  end

  // Unmapped addresses read as zero and are still acknowledged.
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= acc & ~wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (widx[5:2] == `ICPBW_RPT_BASE)
        wb_dat_o <= {rpt_ff[{widx[1:0], 2'h3}], rpt_ff[{widx[1:0], 2'h2}],
                     rpt_ff[{widx[1:0], 2'h1}], rpt_ff[{widx[1:0], 2'h0}]};
      else if (widx[5:3] == `ICPBW_TBL_BASE)
        wb_dat_o <= {24'h00_0000, tbl_ff[{1'b0, widx[2:0]} + 4'h1]};
      else
        unique case (widx)
          `ICPBW_ADR_CMD:    wb_dat_o <= {26'h000_0000, cmd_ff};
          `ICPBW_ADR_CAPS:   wb_dat_o <= {29'h0000_0000, caps_ff};
          `ICPBW_ADR_DROP:   wb_dat_o <= drop_ff;
          `ICPBW_ADR_ADD:    wb_dat_o <= add_ff;
          `ICPBW_ADR_CFGW:   wb_dat_o <= cfgw_ff;
          `ICPBW_ADR_EPMAP:  wb_dat_o <= {18'h0_0000, dif.ctx_index, 1'b0, epmap_ff};
          `ICPBW_ADR_CTXEN:  wb_dat_o <= ctx_enable_o;
          `ICPBW_ADR_CFGOUT: wb_dat_o <= {8'h00, cfgout_ff};
          `ICPBW_ADR_STATUS: wb_dat_o <= {30'h0000_0000, done_ff, busy_o};
          `ICPBW_ADR_GEOM:   wb_dat_o <= {fetch_ff[31:1], 1'b0} | {25'h000_0000, dif.ctl_bytes};
          default:           wb_dat_o <= 32'h0000_0000;
        endcase
    end
  end

  property p_ack_once;
    @(posedge ref_clk_i) disable iff (!rstn_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  property p_ack_next;
    @(posedge ref_clk_i) disable iff (!rstn_i) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not one cycle after request");

  property p_drop;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      state_ff == ST_CTX |=> (ctx_enable_o & $past(dif.drop_mask & ~dif.add_mask)) == 32'h0000_0000;
  endproperty
  a_drop: assert property (p_drop) else $error("dropped context still enabled");

  property p_add;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      state_ff == ST_CTX |=> (ctx_enable_o & $past(add_ff & 32'hFFFF_FFFE)) == $past(add_ff & 32'hFFFF_FFFE);
  endproperty
  a_add: assert property (p_add) else $error("added context not enabled");

  property p_ctl_idx;
    @(posedge ref_clk_i) disable iff (!rstn_i) !ctx_enable_o[0] && !fetch_ff[0];
  endproperty
  a_ctl_idx: assert property (p_ctl_idx) else $error("control entry treated as context");

  property p_cfg_gate;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (state_ff == ST_CTX && !(caps_ff[0] && caps_ff[1] && cmd_ff[2])) |=> cfgout_ff == 24'h00_0000;
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("config info passed without enable");

  property p_intf_gate;
    @(posedge ref_clk_i) disable iff (!rstn_i) (state_ff == ST_CTX && !cmd_ff[3]) |=> cfgout_ff[23:8] == 16'h0000;
  endproperty
  a_intf_gate: assert property (p_intf_gate) else $error("interface bytes without set-interface");

  property p_bw_walk;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      (state_ff == ST_IDLE && start && wb_dat_i[1:0] == 2'h2) |=> (state_ff == ST_BW)[*8] ##1 state_ff == ST_IDLE;
  endproperty
  a_bw_walk: assert property (p_bw_walk) else $error("bandwidth walk not one port per cycle");

  property p_bw_range;
    @(posedge ref_clk_i) disable iff (!rstn_i)
      state_ff == ST_BW |-> dif.bw_pct <= ((cmd_ff[5:4] == 2'b01) ? 8'h50 : 8'h5A);
  endproperty
  a_bw_range: assert property (p_bw_range) else $error("bandwidth percent out of range");

  property p_rpt_rsv;
    @(posedge ref_clk_i) disable iff (!rstn_i) rpt_ff[0] == 8'h00;
  endproperty
  a_rpt_rsv: assert property (p_rpt_rsv) else $error("reserved report byte written");

  c_ctx: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) state_ff == ST_CTX && drop_ff[2]);
  c_bw: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) state_ff == ST_BW && cmd_ff[5:4] == 2'b01);
  c_cfg: cover property (@(posedge ref_clk_i) disable iff (!rstn_i) cfgout_ff[15:8] != 8'h00);
endmodule

// ==== verif/icpbw_wb_host.sv ====
// Purpose: Classic Wishbone master standing in for host software.
// Assumes: One clock; the slave acks before the bench timeout.
// Notes: Signals are zeroed by blocking assignment at time 0, then change only by non-blocking assignment after a rising edge.
`timescale 1ns/10ps
module icpbw_wb_host (
  input  wire logic        clk_i,
  input  wire logic        ack_i,
  input  wire logic [31:0] rdat_i,
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      wdat_o
);
  initial
  begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    wdat_o = 32'h0;
  end

  // Released we, address and data lines show the inverse so a slave cannot lean on stale values; sel stays all ones.
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    adr_o <= adr;
    sel_o <= 4'hF;
    wdat_o <= wd;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rd = rdat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= ~we;
    adr_o <= ~adr;
    wdat_o <= ~wd;
  endtask
endmodule

// ==== verif/icpbw_top_bench.sv ====
// Purpose: Self-checking bench for the input context decoder and bandwidth report.
// Assumes: Host model on the Wishbone port; register map as in the defines header.
// Notes: Expected values come from a small integer model kept here.
`timescale 1ns/10ps
`include "icpbw_defs.svh"
module icpbw_top_bench;
  import icpbw_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        busy;
  logic [31:0] ctx_en;
  int          errors = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          seed = 53224;
  logic [31:0] men = 32'h0;
  logic [31:0] drop;
  logic [31:0] add;
  logic [31:0] cfgw;
  logic [31:0] v;
  logic [31:0] e;
  logic [7:0]  raw [1:8];
  logic [7:0]  lim;
  logic [7:0]  exp_q [$];
  logic [5:0]  idx;
  logic        ok;

  always #25 ref_clk_i = ~ref_clk_i;

  icpbw_top dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy),
    .ctx_enable_o(ctx_en));
  icpbw_wb_host host (.clk_i(ref_clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .wdat_o(wdat));

  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] w, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, {w, 2'b00}, d, r);
  endtask

  task automatic rd(input logic [5:0] w, output logic [31:0] d);
    host.xfer(1'b0, {w, 2'b00}, 32'h0, d);
  endtask

  // Software polls the status until the busy bit clears, then checks and clears done.
  task automatic wait_done();
    logic [31:0] s;
    int n;
    n = 0;
    do
    begin
      rd(`ICPBW_ADR_STATUS, s);
      n++;
    end
    while (s[0] !== 1'b0 && n < 40);
    chk(s[1:0], 32'h2, "status done");
    wr(`ICPBW_ADR_STATUS, 32'h2);
    rd(`ICPBW_ADR_STATUS, s);
    chk(s, 32'h0, "status cleared");
  endtask

  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      test_done();
    end
  end

  initial
  begin
    repeat (3) @(posedge ref_clk_i);
    chk(ctx_en, 32'h0, "reset enables");
    chk({30'h0, busy, ack}, 32'h0, "reset flags");
    rstn_i <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      drop = (i == 1) ? 32'hFFFFFFFF : $random(seed);
      add = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h0 : $random(seed);
      cfgw = $random(seed);
      ok = 1'($random(seed));
      wr(`ICPBW_ADR_CAPS, {29'h0, ok, i[1:0]});
      wr(`ICPBW_ADR_DROP, drop);
      wr(`ICPBW_ADR_ADD, add);
      wr(`ICPBW_ADR_CFGW, cfgw);
      wr(`ICPBW_ADR_CMD, {28'h0, i[3:2], 2'h1});
      wait_done();
      men = (men & ~(drop & 32'hFFFFFFFC)) | (add & 32'hFFFFFFFE);
      chk(ctx_en, men, "context enables");
      rd(`ICPBW_ADR_CTXEN, v);
      chk(v, men, "context read");
      e = {8'h0, (i[1:0] == 2'h3 && i[2] && i[3]) ? cfgw[23:8] : 16'h0, (i[1:0] == 2'h3 && i[2]) ? cfgw[7:0] : 8'h0};
      rd(`ICPBW_ADR_CFGOUT, v);
      chk(v, e, "config bytes");
      rd(`ICPBW_ADR_GEOM, v);
      chk(v, (add & 32'hFFFFFFFE) | (ok ? 32'h40 : 32'h20), "fetch and size");
    end
    for (int k = 0; k < 128; k++)
    begin
      idx = (k[6:5] == 2'h0) ? 6'((k[3:0] + 1) * 2) : 6'(k[3:0] * 2 + 1 + k[4]);
      wr(`ICPBW_ADR_EPMAP, {25'h0, k[6:0]});
      rd(`ICPBW_ADR_EPMAP, v);
      chk(v, {18'h0, idx, 1'b0, k[6:0]}, "endpoint index");
    end
    for (int sp = 0; sp < 4; sp++)
    begin
      lim = (sp == 1) ? 8'h50 : 8'h5A;
      exp_q.delete();
      exp_q.push_back(8'h00);
      for (int p = 1; p <= 8; p++)
      begin
        v = $random(seed);
        raw[p] = (p == 1) ? lim : (p == 2) ? lim + 8'h1 : (p == 3) ? 8'h00 : v[7:0];
        exp_q.push_back((raw[p] > lim) ? lim : raw[p]);
        wr({`ICPBW_TBL_BASE, 3'(p - 1)}, {v[31:8], raw[p]});
      end
      while (exp_q.size() < `ICPBW_RPT_BYTES)
        exp_q.push_back(8'h00);
      wr(`ICPBW_ADR_CMD, {26'h0, 2'(sp), 2'b00, 2'h2});
      wr(`ICPBW_ADR_DROP, 32'hFFFFFFFF);
      chk({31'h0, busy}, 32'h1, "busy during walk");
      wait_done();
      for (int w = 0; w < 4; w++)
      begin
        for (int b = 0; b < 4; b++)
        begin
          e[b*8 +: 8] = exp_q.pop_front();
        end
        rd({`ICPBW_RPT_BASE, 2'(w)}, v);
        chk(v, e, "bandwidth report");
      end
    end
    wr(`ICPBW_ADR_CMD, 32'h1);
    wait_done();
    chk(ctx_en, men, "drop write refused while busy");
    rd(6'h0C, v);
    chk(v, 32'h0, "unmapped read");
    test_done();
  end
endmodule
